// [phase_defs.vh]
// Purpose: Shared constants for the phase counting timer.
// Assumes: One 40 MHz clock, synchronous active-high reset.
// Notes: Channel slots 0..3 map to timer channels 1, 2, 4 and 5.
//
// Operation
// - Counter follows phase of two external inputs.
// - Four phase modes, differing in counting conditions.
// - Channels 1,5 use A/B; 2,4 use C/D.
// - Mode 1 counts on every edge, level-qualified.
`ifndef PHASE_DEFS_VH
`define PHASE_DEFS_VH

// ==========================================================================
// Widths
`define COUNT_W 16
`define MODE_W 2
`define CHAN_N 4

// ==========================================================================
// Phase counting mode encodings
`define MODE_PHASE_1 2'h0
`define MODE_PHASE_2 2'h1
`define MODE_PHASE_3 2'h2
`define MODE_PHASE_4 2'h3

// ==========================================================================
// Reset values and counter limits
`define COUNTER_RESET 16'h0000
`define COUNTER_MAX 16'hffff
`define SYNC_RESET 1'b0

// ==========================================================================
// Channel slot that each input pair feeds
`define SLOT_CH1 0
`define SLOT_CH2 1
`define SLOT_CH4 2
`define SLOT_CH5 3

`endif

// [phase_sampler.v]
// Purpose: Synchronise one pair of phase inputs and find their edges.
// Assumes: Inputs may change at any time relative to clk.
// Notes: Edges appear two clocks after the pin changes.
`timescale 1ns/1ps
`default_nettype none
`include "phase_defs.vh"

module phase_sampler (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Phase pins
  input wire pin_first,
  input wire pin_second,
  // Sampled levels and edges
  output wire level_first,
  output wire level_second,
  output wire rise_first,
  output wire fall_first,
  output wire rise_second,
  output wire fall_second
);

  // ==========================================================================
  // Two-stage synchroniser and history sample
  reg [1:0] meta;
  reg [1:0] stable;
  reg [1:0] history;

  // The first stage feeds only the second; edges are taken between the
  // second stage and the history register.
  always @(posedge clk)
  begin
    if (srst)
    begin
      meta <= {2{`SYNC_RESET}};
      stable <= {2{`SYNC_RESET}};
      history <= {2{`SYNC_RESET}};
    end
    else
    begin
      meta <= {pin_second, pin_first};
      stable <= meta;
      history <= stable;
    end
  end

  // ==========================================================================
  // Edge detection by comparing successive samples
  assign level_first = stable[0];
  assign level_second = stable[1];
  assign rise_first = stable[0] & ~history[0];
  assign fall_first = ~stable[0] & history[0];
  assign rise_second = stable[1] & ~history[1];
  assign fall_second = ~stable[1] & history[1];

endmodule
`default_nettype wire

// [phase_counting_timer.v]
// Purpose: Phase counting counters for timer channels 1, 2, 4 and 5.
// Assumes: Control inputs are synchronous to clk and held by the owner.
// Notes: Clear beats load, load beats a count step.
// A step that meets a clear or load is dropped, not deferred.
`timescale 1ns/1ps
`default_nettype none
`include "phase_defs.vh"

module phase_counting_timer (
  // Clock and reset
  input wire clk,
  input wire srst,
  // External phase pins
  input wire ext_phase_in_a,
  input wire ext_phase_in_b,
  input wire ext_phase_in_c,
  input wire ext_phase_in_d,
  // Per-slot control, slot order ch1, ch2, ch4, ch5
  input wire [`CHAN_N-1:0] phase_enable,
  input wire [`CHAN_N*`MODE_W-1:0] phase_mode,
  input wire [`CHAN_N-1:0] counter_clear,
  input wire [`CHAN_N-1:0] counter_load,
  input wire [`COUNT_W-1:0] load_value,
  // Counter values
  output reg [`COUNT_W-1:0] channel_counter_ch1,
  output reg [`COUNT_W-1:0] channel_counter_ch2,
  output reg [`COUNT_W-1:0] channel_counter_ch4,
  output reg [`COUNT_W-1:0] channel_counter_ch5,
  // Status
  output reg [`CHAN_N-1:0] count_up_dir,
  output reg [`CHAN_N-1:0] step_pulse,
  output reg [`CHAN_N-1:0] overflow_pulse,
  output reg [`CHAN_N-1:0] underflow_pulse
);

  // ==========================================================================
  // Input sampling
  // A and C act as the first input, B and D as the second, in every mode.
  wire ab_lvl_a;
  wire ab_lvl_b;
  wire ab_rise_a;
  wire ab_fall_a;
  wire ab_rise_b;
  wire ab_fall_b;
  wire cd_lvl_c;
  wire cd_lvl_d;
  wire cd_rise_c;
  wire cd_fall_c;
  wire cd_rise_d;
  wire cd_fall_d;

  // One sampler per pin pair; channels sharing a pair see identical edges.
  phase_sampler sample_ab (
    .clk(clk),
    .srst(srst),
    .pin_first(ext_phase_in_a),
    .pin_second(ext_phase_in_b),
    .level_first(ab_lvl_a),
    .level_second(ab_lvl_b),
    .rise_first(ab_rise_a),
    .fall_first(ab_fall_a),
    .rise_second(ab_rise_b),
    .fall_second(ab_fall_b)
  );

  phase_sampler sample_cd (
    .clk(clk),
    .srst(srst),
    .pin_first(ext_phase_in_c),
    .pin_second(ext_phase_in_d),
    .level_first(cd_lvl_c),
    .level_second(cd_lvl_d),
    .rise_first(cd_rise_c),
    .fall_first(cd_fall_c),
    .rise_second(cd_rise_d),
    .fall_second(cd_fall_d)
  );

  // ==========================================================================
  // Count condition decode
  // Returns {up, down}. Levels are those sampled with the edge.
  function [1:0] decode_step;
    input [`MODE_W-1:0] mode;
    input lvl_a;
    input lvl_b;
    input rise_a;
    input fall_a;
    input rise_b;
    input fall_b;
    reg up_a;
    reg dn_a;
    reg up_b;
    reg dn_b;
    begin
      up_a = (rise_a & ~lvl_b) | (fall_a & lvl_b);
      dn_a = (rise_a & lvl_b) | (fall_a & ~lvl_b);
      up_b = (rise_b & lvl_a) | (fall_b & ~lvl_a);
      dn_b = (rise_b & ~lvl_a) | (fall_b & lvl_a);
      // Modes 2 and 3 are this block's own choice; mode 4 counts only
      // second-input edges, qualified by the first input's level.
      case (mode)
        `MODE_PHASE_1:
          decode_step = {up_a | up_b, dn_a | dn_b};
        `MODE_PHASE_2:
          decode_step = {fall_a & lvl_b, fall_a & ~lvl_b};
        `MODE_PHASE_3:
          decode_step = {up_a, dn_a};
        `MODE_PHASE_4:
          decode_step = {up_b, dn_b};
        default:
          decode_step = 2'b00;
      endcase
    end
  endfunction

  // ==========================================================================
  // Per-slot counters
  wire [`CHAN_N*`COUNT_W-1:0] count_flat;

  genvar g;
  generate
    for (g = 0; g < `CHAN_N; g = g + 1)
    begin : slot
      // Slots 0 and 3 (channels 1 and 5) use A/B, slots 1 and 2 use C/D.
      localparam USE_AB = (g == `SLOT_CH1) || (g == `SLOT_CH5);

      wire lvl_a = USE_AB ? ab_lvl_a : cd_lvl_c;
      wire lvl_b = USE_AB ? ab_lvl_b : cd_lvl_d;
      wire rise_a = USE_AB ? ab_rise_a : cd_rise_c;
      wire fall_a = USE_AB ? ab_fall_a : cd_fall_c;
      wire rise_b = USE_AB ? ab_rise_b : cd_rise_d;
      wire fall_b = USE_AB ? ab_fall_b : cd_fall_d;

      wire [`MODE_W-1:0] mode = phase_mode[g*`MODE_W +: `MODE_W];
      wire [1:0] dir = decode_step(mode, lvl_a, lvl_b, rise_a, fall_a, rise_b, fall_b);

      // In mode 1, both inputs moving in one sample gives no defined phase, so both
      // directions cancel and nothing is counted.
      wire step_up = phase_enable[g] & dir[1] & ~dir[0];
      wire step_dn = phase_enable[g] & dir[0] & ~dir[1];

      reg [`COUNT_W-1:0] counter;
      reg [`COUNT_W-1:0] next_counter;

      always @*
      begin
        next_counter = counter;
        if (counter_clear[g])
          next_counter = `COUNTER_RESET;
        else if (counter_load[g])
          next_counter = load_value;
        else if (step_up)
          next_counter = counter + 16'h0001;
        else if (step_dn)
          next_counter = counter - 16'h0001;
      end

      // A clear or load owns the counter for that cycle; the step it meets
      // is lost, so no pulse may claim that it happened.
      wire ctl_hold = counter_clear[g] | counter_load[g];
      wire wrap_up = step_up & (counter == `COUNTER_MAX);
      wire wrap_dn = step_dn & (counter == `COUNTER_RESET);

      // ==========================================================================
      // Counter register
      always @(posedge clk)
      begin
        if (srst)
          counter <= `COUNTER_RESET;
        else
          counter <= next_counter;
      end

      // ==========================================================================
      // Status flags
      // The direction flag follows every decoded step of an enabled slot, even one lost to a
      // clear or load; while the slot is disabled it holds its last direction.
      always @(posedge clk)
      begin
        if (srst)
        begin
          count_up_dir[g] <= 1'b0;
          step_pulse[g] <= 1'b0;
          overflow_pulse[g] <= 1'b0;
          underflow_pulse[g] <= 1'b0;
        end
        else
        begin
          step_pulse[g] <= ~ctl_hold & (step_up | step_dn);
          overflow_pulse[g] <= ~ctl_hold & wrap_up;
          underflow_pulse[g] <= ~ctl_hold & wrap_dn;
          if (step_up)
            count_up_dir[g] <= 1'b1;
          else if (step_dn)
            count_up_dir[g] <= 1'b0;
        end
      end

      assign count_flat[g*`COUNT_W +: `COUNT_W] = next_counter;
    end
  endgenerate

  // ==========================================================================
  // Counter outputs
  // The outputs are their own flops loaded with the same next value, so they
  // match the internal counters on every cycle.
  always @(posedge clk)
  begin
    if (srst)
    begin
      channel_counter_ch1 <= `COUNTER_RESET;
      channel_counter_ch2 <= `COUNTER_RESET;
      channel_counter_ch4 <= `COUNTER_RESET;
      channel_counter_ch5 <= `COUNTER_RESET;
    end
    else
    begin
      channel_counter_ch1 <= count_flat[`SLOT_CH1*`COUNT_W +: `COUNT_W];
      channel_counter_ch2 <= count_flat[`SLOT_CH2*`COUNT_W +: `COUNT_W];
      channel_counter_ch4 <= count_flat[`SLOT_CH4*`COUNT_W +: `COUNT_W];
      channel_counter_ch5 <= count_flat[`SLOT_CH5*`COUNT_W +: `COUNT_W];
    end
  end

endmodule
`default_nettype wire

// [quad_encoder_model.sv]
// Purpose: Two-phase encoder driving one pair of phase pins.
// Assumes: Step requests change only after a falling edge.
// Notes: One pin changes per step, as on a real encoder.
`timescale 1ns/1ps
`default_nettype none
module quad_encoder_model (
  // Clock and step request
  input wire logic clk,
  input wire logic go,
  input wire logic up,
  // Phase pins
  output logic pin_first,
  output logic pin_second
);
  logic [1:0] pos = 2'h0;
  // Forward order 00, 10, 11, 01 is the up direction.
  assign pin_first = ^pos;
  assign pin_second = pos[1];
  always @(posedge clk)
  begin
    if (go)
      pos <= up ? pos + 2'h1 : pos - 2'h1;
  end
endmodule
`default_nettype wire

// [phase_counting_timer_sva.sv]
// Purpose: Port checker for the phase counting timer.
// Assumes: Mode and controls stay still around pin edges.
// Notes: A pin edge shows at the outputs three samples later.
`timescale 1ns/1ps
`default_nettype none
module phase_counting_checker (
  // Clock, reset and pins
  input wire clk,
  input wire srst,
  input wire ext_phase_in_a,
  input wire ext_phase_in_b,
  // Control and status
  input wire [3:0] phase_enable,
  input wire [7:0] phase_mode,
  input wire [3:0] counter_clear,
  input wire [3:0] counter_load,
  input wire [15:0] channel_counter_ch1,
  input wire [15:0] channel_counter_ch2,
  input wire [15:0] channel_counter_ch4,
  input wire [15:0] channel_counter_ch5,
  input wire [3:0] count_up_dir,
  input wire [3:0] step_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wire m1_ok = phase_enable[0] && phase_mode[1:0] == 2'h0 && !counter_clear[0] && !counter_load[0];
  sequence ab_still;
    $stable(ext_phase_in_a) && $stable(ext_phase_in_b);
  endsequence
  sequence b_rise_a_hi;
    m1_ok && $rose(ext_phase_in_b) && ext_phase_in_a && $stable(ext_phase_in_a);
  endsequence
  a_up_step_adds: assert property (step_pulse[0] && count_up_dir[0] |->
    channel_counter_ch1 == $past(channel_counter_ch1) + 16'h0001) else $error("ch1 up step");
  a_down_step_subs: assert property (step_pulse[1] && !count_up_dir[1] |->
    channel_counter_ch2 == $past(channel_counter_ch2) - 16'h0001) else $error("ch2 down step");
  a_mode1_rise_up: assert property (b_rise_a_hi |-> ##3 step_pulse[0] && count_up_dir[0])
    else $error("mode 1 rise missed");
  a_mode1_fall_down: assert property (m1_ok && $fell(ext_phase_in_a) && !ext_phase_in_b
    && $stable(ext_phase_in_b) |-> ##3 step_pulse[0] && !count_up_dir[0]) else $error("mode 1 fall");
  a_mode4_first_idle: assert property (phase_mode[7:6] == 2'h3 && $changed(ext_phase_in_a)
    && $stable(ext_phase_in_b) |-> ##3 !step_pulse[3]) else $error("mode 4 counted first pin");
  a_still_no_step: assert property (ab_still [*3] |=> !step_pulse[0] && !step_pulse[3])
    else $error("step without pin edge");
  a_ch4_step_moves: assert property (step_pulse[2] |-> channel_counter_ch4 ==
    $past(channel_counter_ch4) + (count_up_dir[2] ? 16'h0001 : 16'hffff)) else $error("ch4 step");
  a_ch5_step_moves: assert property (step_pulse[3] |-> channel_counter_ch5 ==
    $past(channel_counter_ch5) + (count_up_dir[3] ? 16'h0001 : 16'hffff)) else $error("ch5 step");
endmodule
`default_nettype wire

// [phase_counting_timer_tb.sv]
// Purpose: Random walk bench for the phase counting timer.
// Assumes: Pins step one at a time, at least two cycles apart.
// Notes: Each batch gives every slot another mode.
`timescale 1ns/1ps
`default_nettype none
module phase_counting_timer_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] en = 4'h0, clr = 4'h0, ld = 4'h0;
  logic [7:0] mode = 8'h00;
  logic [15:0] lv = 16'h0000;
  logic [1:0] go = 2'h0, up = 2'h0;
  logic [15:0] exp_q [0:3];
  logic [1:0] pos [0:1];
  logic [31:0] seed = 32'h3899_d278;
  wire a, b, c, d;
  wire [15:0] q1, q2, q4, q5;
  wire [3:0] ovf, unf;
  integer fail_count = 0, checks = 0, cyc = 0, n, s, g, p;
  integer exp_ovf = 0, exp_unf = 0, ovf_n = 0, unf_n = 0;
  always #12.5 clk = ~clk;
  quad_encoder_model enc_ab (.clk(clk), .go(go[0]), .up(up[0]), .pin_first(a), .pin_second(b));
  quad_encoder_model enc_cd (.clk(clk), .go(go[1]), .up(up[1]), .pin_first(c), .pin_second(d));
  phase_counting_timer dut_u (.clk(clk), .srst(srst), .ext_phase_in_a(a), .ext_phase_in_b(b),
    .ext_phase_in_c(c), .ext_phase_in_d(d), .phase_enable(en), .phase_mode(mode),
    .counter_clear(clr), .counter_load(ld), .load_value(lv), .channel_counter_ch1(q1),
    .channel_counter_ch2(q2), .channel_counter_ch4(q4), .channel_counter_ch5(q5),
    .count_up_dir(), .step_pulse(), .overflow_pulse(ovf), .underflow_pulse(unf));
  // Wrap pulses last one cycle, so each is counted once at a falling edge.
  always @(negedge clk)
  begin
    ovf_n = ovf_n + ovf[0] + ovf[1] + ovf[2] + ovf[3];
    unf_n = unf_n + unf[0] + unf[1] + unf[2] + unf[3];
  end
  function [31:0] xs(input [31:0] x);
    begin
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  // Whether mode m counts a step taken from encoder position q.
  function counts(input [1:0] m, input [1:0] q, input u);
    begin
      case (m)
        2'h0: counts = 1'b1;
        2'h1: counts = u ? q == 2'h2 : q == 2'h1;
        2'h2: counts = u ? !q[0] : q[0];
        default: counts = u ? q[0] : !q[0];
      endcase
    end
  endfunction
  task chk(input [31:0] name, input [15:0] e, input [15:0] v);
    begin
      checks = checks + 1;
      if (v !== e)
      begin
        fail_count = fail_count + 1;
        $display("ERROR %0s expected %h seen %h", name, e, v);
      end
    end
  endtask
  task chk_all;
    begin
      chk("ch1", exp_q[0], q1);
      chk("ch2", exp_q[1], q2);
      chk("ch4", exp_q[2], q4);
      chk("ch5", exp_q[3], q5);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 6000)
    begin
      fail_count = fail_count + 1;
      complete_run;
    end
  end
  initial
  begin
    pos[0] = 2'h0;
    pos[1] = 2'h0;
    for (g = 0; g < 4; g = g + 1)
      exp_q[g] = 16'h0000;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    chk_all;
    for (n = 0; n < 4; n = n + 1)
    begin
      // The first two batches load all ones, then zero, so steps can wrap.
      lv = (n == 0) ? 16'hffff : (n == 1) ? 16'h0000 : seed[15:0];
      ld = 4'hf;
      en = (n == 3) ? 4'hb : 4'hf;
      for (g = 0; g < 4; g = g + 1)
      begin
        mode[2*g +: 2] = g[1:0] + n[1:0];
        exp_q[g] = lv;
      end
      @(negedge clk);
      ld = 4'h0;
      for (s = 0; s < 40; s = s + 1)
      begin
        seed = xs(seed);
        go = seed[1:0];
        up = seed[3:2];
        for (g = 0; g < 4; g = g + 1)
        begin
          p = (g == 1 || g == 2);
          if (go[p] && en[g] && counts(mode[2*g +: 2], pos[p], up[p]))
          begin
            if (up[p] && exp_q[g] == 16'hffff)
              exp_ovf = exp_ovf + 1;
            if (!up[p] && exp_q[g] == 16'h0000)
              exp_unf = exp_unf + 1;
            exp_q[g] = up[p] ? exp_q[g] + 16'h0001 : exp_q[g] - 16'h0001;
          end
        end
        for (p = 0; p < 2; p = p + 1)
          if (go[p])
            pos[p] = up[p] ? pos[p] + 2'h1 : pos[p] - 2'h1;
        @(negedge clk);
        go = 2'h0;
        repeat (1 + seed[5:4]) @(negedge clk);
      end
      repeat (4) @(negedge clk);
      chk_all;
    end
    clr = 4'hf;
    for (g = 0; g < 4; g = g + 1)
      exp_q[g] = 16'h0000;
    @(negedge clk);
    clr = 4'h0;
    chk_all;
    chk("ovf", exp_ovf[15:0], ovf_n[15:0]);
    chk("unf", exp_unf[15:0], unf_n[15:0]);
    complete_run;
  end
endmodule
bind phase_counting_timer phase_counting_checker chk_u (.clk(clk), .srst(srst),
  .ext_phase_in_a(ext_phase_in_a), .ext_phase_in_b(ext_phase_in_b), .phase_enable(phase_enable),
  .phase_mode(phase_mode), .counter_clear(counter_clear), .counter_load(counter_load),
  .channel_counter_ch1(channel_counter_ch1), .channel_counter_ch2(channel_counter_ch2),
  .channel_counter_ch4(channel_counter_ch4), .channel_counter_ch5(channel_counter_ch5),
  .count_up_dir(count_up_dir), .step_pulse(step_pulse));
`default_nettype wire
